// *** common/sscs_map.vh ***
// constants for the slow channel sequencer: setup bits, message ids, data values
`ifndef SSCS_MAP_VH
`define SSCS_MAP_VH

// protocol setup word field positions
`define SSCS_SETUP_WIDTH 16
`define SSCS_BIT_INTERLEAVE 3
`define SSCS_BIT_SLOW_OFF 4
`define SSCS_BIT_FAST_ERR_OFF 5
`define SSCS_BIT_CRC_STATUS 10
`define SSCS_BIT_CRC_LEGACY 11
`define SSCS_BIT_BLK2_EN 12
`define SSCS_BIT_BLK3_EN 13
`define SSCS_BIT_BLK4_EN 14
`define SSCS_BIT_BLK5_EN 15

// message word layout: id in the upper byte, data in the low 12 bits
`define SSCS_ID_WIDTH 8
`define SSCS_DATA_WIDTH 12
`define SSCS_MSG_WIDTH 20
`define SSCS_FIFO_DEPTH 4
`define SSCS_FIFO_AW 2

// message identifiers
`define SSCS_ID_ERROR 8'h01
`define SSCS_ID_SENSOR_TYPE 8'h03
`define SSCS_ID_MFR 8'h05
`define SSCS_ID_PROTO_REV 8'h06
`define SSCS_ID_TEMP 8'h23
`define SSCS_ID_SERIAL_BASE 8'h29
`define SSCS_ID_FAST_CHAR_BASE 8'h07
`define SSCS_ID_OEM_A_BASE 8'h90
`define SSCS_ID_OEM_B_BASE 8'h94

// fixed data values
`define SSCS_PROTO_REV_VALUE 12'h004
`define SSCS_TEMP_MIN 12'h001
`define SSCS_TEMP_MAX 12'hFF8
`define SSCS_FAST_ERR_FUNC 12'hFFA
`define SSCS_FAST_ERR_SENSOR 12'hFFB

// sequence shape
`define SSCS_LAST_BLOCK 3'h4
`define SSCS_LAST_INDEX 3'h4

// crc constants
`define SSCS_CRC_SEED 4'h5
`define SSCS_CRC_POLY 5'h1D

`endif

// *** logic/sscs_fifo.v ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sscs_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;
  integer i;

  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_reg[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // sscs_fifo

// *** logic/sscs_sequencer.v ***
// slow channel message sequencer, fast channel crc and error payload mapping
// Behaviour
// (R1) recommended crc by default; legacy crc when setup bit 11 set
// (R2) setup bit 10 puts the status nibble into the crc
// (R3) each slow message carries 8-bit id and 12-bit data
// (R4) setup bit 4 stops all slow channel messages; words already in the fifo (up to 4) still go out
// (R5) up to five blocks form the sequence; blocks 2 to 5 each enabled by configuration
// (R6) block 1 is always sent while the slow channel is on
// (R7) block 1: ids 01, 03, 05, 06 (revision 4), 23 in order
// (R8) temperature data held within 1 to 4088
// (R9) sensor type data is customer word 0 bits 11:0
// (R10) block 3: error code then ids 07..0A from customer words 1..3
// (R11) 12-bit values packed contiguously across 16-bit customer words
// (R12) block 4: error code then ids 90..93 from customer words 4..6
// (R13) block 5: error code then ids 94..97 from customer words 7..9
// (R14) diagnostics use id 01; every block starts with it
// (R15) optional mode sends the error code as every second message
// (R16) error bits 0..5: memory, adc/dsp, regulator, clipping, temperature, path
// (R17) bits 6,7,9,10 over/under voltage, hall, field; 8 reserved; 11 one
// (R18) fast channel mirror: 4090 or 4091 codes, path overflow clamps to limits
// (R19) block 2: error code then ids 29..2C, one serial byte each
// (R20) after last enabled block restart at block 1, repeating
// (R21) receiver decodes by id, not by position
`timescale 1ns/1ps
`include "sscs_map.vh"
module sscs_sequencer #(
  // manufacturer code: arbitrary neutral value
  parameter [11:0] MFR_CODE = 12'h0A5
) (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // configuration
  input wire [15:0] setup_protocol,
  input wire [15:0] customer_word_0,
  input wire [15:0] customer_word_1,
  input wire [15:0] customer_word_2,
  input wire [15:0] customer_word_3,
  input wire [15:0] customer_word_4,
  input wire [15:0] customer_word_5,
  input wire [15:0] customer_word_6,
  input wire [15:0] customer_word_7,
  input wire [15:0] customer_word_8,
  input wire [15:0] customer_word_9,
  input wire [15:0] serial_number_high_word,
  input wire [15:0] serial_number_low_word,
  input wire [11:0] clamp_low,
  input wire [11:0] clamp_high,
  // live sensor state
  input wire [11:0] temperature_code,
  input wire [10:0] error_flags,
  input wire [11:0] fast_value,
  // fast channel frame for crc
  input wire [3:0] frame_status,
  input wire [23:0] frame_data,
  output reg [3:0] frame_crc,
  output reg [11:0] fast_payload,
  // slow channel message stream
  output wire slow_valid,
  input wire slow_ready,
  output wire [7:0] slow_id,
  output wire [11:0] slow_data,
  output wire [2:0] slow_block,
  output wire slow_active
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg state_reg;
  reg state_next;
  reg [2:0] block_reg;
  reg [2:0] block_next;
  reg [2:0] index_reg;
  reg [2:0] index_next;
  reg pend_err_reg;
  reg pend_err_next;
  reg [19:0] msg;
  reg [11:0] temp_sat;
  reg [11:0] err_word;
  reg [3:0] crc_calc;
  reg [11:0] fast_next;
  wire slow_off;
  wire [4:0] blk_en;
  wire push;
  wire fifo_in_ready;
  wire [19:0] fifo_out;
  integer k;

  assign slow_off = setup_protocol[`SSCS_BIT_SLOW_OFF]; // R4
  assign blk_en = {setup_protocol[`SSCS_BIT_BLK5_EN], setup_protocol[`SSCS_BIT_BLK4_EN],
                   setup_protocol[`SSCS_BIT_BLK3_EN], setup_protocol[`SSCS_BIT_BLK2_EN],
                   1'b1}; // R5 R6

  // one crc step: shift the running value four bits through the polynomial, then fold in the nibble
  function [3:0] crc_step;
    input [3:0] c;
    input [3:0] n;
    reg [4:0] r;
    integer j;
    begin
      r = {1'b0, c};
      for (j = 0; j < 4; j = j + 1) begin
        r = {r[3:0], 1'b0};
        if (r[4]) begin
          r = r ^ `SSCS_CRC_POLY;
        end
      end
      crc_step = r[3:0] ^ n;
    end
  endfunction

  // k-th of four 12-bit values packed across three 16-bit words
  function [11:0] unpack;
    input [1:0] idx;
    input [15:0] wa;
    input [15:0] wb;
    input [15:0] wc;
    begin
      case (idx)
        2'h0: unpack = wa[11:0];
        2'h1: unpack = {wb[7:0], wa[15:12]};
        2'h2: unpack = {wc[3:0], wb[15:8]};
        default: unpack = wc[15:4];
      endcase
    end
  endfunction // R11

  // next enabled block after b, wrapping to block 1
  function [2:0] next_block;
    input [2:0] b;
    input [4:0] en;
    reg [2:0] r;
    reg found;
    integer j;
    begin
      r = 3'h0;
      found = 1'b0;
      for (j = 1; j < 5; j = j + 1) begin
        if (!found && (j > b) && en[j]) begin
          r = j[2:0];
          found = 1'b1;
        end
      end
      next_block = r;
    end
  endfunction // R20

  // error code word
  always @* begin
    err_word = {1'b1, error_flags}; // R16 R17
    err_word[8] = 1'b0;
  end

  // temperature confined to the legal range
  always @* begin
    if (temperature_code < `SSCS_TEMP_MIN) begin
      temp_sat = `SSCS_TEMP_MIN;
    end else if (temperature_code > `SSCS_TEMP_MAX) begin
      temp_sat = `SSCS_TEMP_MAX;
    end else begin
      temp_sat = temperature_code;
    end
  end // R8

  // message selection
  always @* begin
    msg = {`SSCS_ID_ERROR, err_word};
    if (pend_err_reg || index_reg == 3'h0) begin
      msg = {`SSCS_ID_ERROR, err_word}; // R14 R15
    end else begin
      case (block_reg)
        3'h0: begin
          case (index_reg)
            3'h1: msg = {`SSCS_ID_SENSOR_TYPE, customer_word_0[11:0]}; // R9
            3'h2: msg = {`SSCS_ID_MFR, MFR_CODE};
            3'h3: msg = {`SSCS_ID_PROTO_REV, `SSCS_PROTO_REV_VALUE};
            default: msg = {`SSCS_ID_TEMP, temp_sat};
          endcase
        end // R7
        3'h1: begin
          case (index_reg)
            3'h1: msg = {`SSCS_ID_SERIAL_BASE, 4'h0, serial_number_high_word[15:8]};
            3'h2: msg = {`SSCS_ID_SERIAL_BASE + 8'h01, 4'h0, serial_number_high_word[7:0]};
            3'h3: msg = {`SSCS_ID_SERIAL_BASE + 8'h02, 4'h0, serial_number_low_word[15:8]};
            default: msg = {`SSCS_ID_SERIAL_BASE + 8'h03, 4'h0, serial_number_low_word[7:0]};
          endcase
        end // R19
        3'h2: msg = {`SSCS_ID_FAST_CHAR_BASE + {5'h00, index_reg} - 8'h01,
                     unpack(index_reg[1:0] - 2'h1, customer_word_1, customer_word_2,
                            customer_word_3)}; // R10
        3'h3: msg = {`SSCS_ID_OEM_A_BASE + {5'h00, index_reg} - 8'h01,
                     unpack(index_reg[1:0] - 2'h1, customer_word_4, customer_word_5,
                            customer_word_6)}; // R12
        default: msg = {`SSCS_ID_OEM_B_BASE + {5'h00, index_reg} - 8'h01,
                        unpack(index_reg[1:0] - 2'h1, customer_word_7, customer_word_8,
                               customer_word_9)}; // R13
      endcase
    end
  end // R3

  assign push = (state_reg == ST_RUN) && !slow_off;

  // sequence walk, advanced only when the fifo takes a word
  always @* begin
    state_next = state_reg;
    block_next = block_reg;
    index_next = index_reg;
    pend_err_next = pend_err_reg;
    case (state_reg)
      ST_IDLE: begin
        block_next = 3'h0;
        index_next = 3'h0;
        pend_err_next = 1'b0;
        if (!slow_off) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (slow_off) begin
          state_next = ST_IDLE; // R4
        end else if (fifo_in_ready) begin
          if (pend_err_reg) begin
            pend_err_next = 1'b0;
          end else if (index_reg == `SSCS_LAST_INDEX) begin
            index_next = 3'h0;
            block_next = next_block(block_reg, blk_en); // R5 R20
          end else begin
            index_next = index_reg + 3'h1;
            // interleave only between data words; the block start brings its own
            pend_err_next = setup_protocol[`SSCS_BIT_INTERLEAVE] && (index_reg != 3'h0)
                            && (index_reg != 3'h0); // R15
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      block_reg <= 3'h0;
      index_reg <= 3'h0;
      pend_err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      block_reg <= block_next;
      index_reg <= index_next;
      pend_err_reg <= pend_err_next;
    end
  end

  // fast channel crc over status (optional) and six data nibbles
  always @* begin
    crc_calc = `SSCS_CRC_SEED;
    if (setup_protocol[`SSCS_BIT_CRC_STATUS]) begin
      crc_calc = crc_step(crc_calc, frame_status); // R2
    end
    for (k = 5; k >= 0; k = k - 1) begin
      crc_calc = crc_step(crc_calc, frame_data[k*4 +: 4]);
    end
    if (!setup_protocol[`SSCS_BIT_CRC_LEGACY]) begin
      // recommended variant augments with a zero nibble
      crc_calc = crc_step(crc_calc, 4'h0); // R1
    end
  end

  // fast channel payload with error mirroring
  always @* begin
    fast_next = fast_value;
    if (!setup_protocol[`SSCS_BIT_FAST_ERR_OFF]) begin
      if (error_flags[0] || error_flags[1] || error_flags[2] || error_flags[4] || error_flags[9]) begin
        fast_next = `SSCS_FAST_ERR_FUNC;
      end else if (error_flags[3] || error_flags[6] || error_flags[7] || error_flags[10]) begin
        fast_next = `SSCS_FAST_ERR_SENSOR;
      end else if (error_flags[5]) begin
        fast_next = (fast_value > clamp_high) ? clamp_high : clamp_low;
      end
    end
  end // R18

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_crc <= 4'h0;
      fast_payload <= 12'h000;
    end else begin
      frame_crc <= crc_calc;
      fast_payload <= fast_next;
    end
  end

  // fifo decouples the sequencer from the frame scheduler's pace
  sscs_fifo #(
    .WIDTH(`SSCS_MSG_WIDTH),
    .DEPTH(`SSCS_FIFO_DEPTH),
    .AW(`SSCS_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(msg),
    .out_valid(slow_valid),
    .out_ready(slow_ready),
    .out_data(fifo_out)
  );

  assign slow_id = fifo_out[19:12];
  assign slow_data = fifo_out[11:0];
  assign slow_block = block_reg;
  assign slow_active = (state_reg == ST_RUN);
endmodule // sscs_sequencer

// *** verification/sscs_chk_sva.sv ***
// port-level assertions for the slow channel sequencer
`timescale 1ns/1ps
module sscs_chk #(
  parameter [11:0] MFR_CODE = 12'h0A5
) (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // configuration and sensor state
  input wire [15:0] setup_protocol,
  input wire [15:0] customer_word_0,
  input wire [15:0] serial_number_high_word,
  input wire [10:0] error_flags,
  input wire [11:0] fast_value,
  input wire [11:0] fast_payload,
  // slow channel
  input wire slow_valid,
  input wire slow_ready,
  input wire [7:0] slow_id,
  input wire [11:0] slow_data,
  input wire slow_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  word_stands_a: assert property (slow_valid && !slow_ready |=> slow_valid && $stable(slow_id) && $stable(slow_data))
    else $error("slow word changed before it was taken");
  // three cycles allow for the sequencer state to settle
  slow_off_a: assert property (setup_protocol[4] [*3] |-> !slow_active)
    else $error("sequencer active while slow channel off");
  no_push_a: assert property (setup_protocol[4] [*3] ##0 !slow_valid |=> !slow_valid)
    else $error("word pushed while slow channel off");
  err_word_a: assert property (slow_valid && slow_id == 8'h01 |-> slow_data[11] && !slow_data[8])
    else $error("error word fixed bits wrong");
  mfr_data_a: assert property (slow_valid && slow_id == 8'h05 |-> slow_data == MFR_CODE)
    else $error("manufacturer data wrong");
  rev_data_a: assert property (slow_valid && slow_id == 8'h06 |-> slow_data == 12'h004)
    else $error("revision data wrong");
  temp_range_a: assert property (slow_valid && slow_id == 8'h23 |-> slow_data >= 12'h001 && slow_data <= 12'hFF8)
    else $error("temperature out of range");
  sensor_type_a: assert property (slow_valid && slow_id == 8'h03 |-> slow_data == customer_word_0[11:0])
    else $error("sensor type data wrong");
  serial_hi_a: assert property (slow_valid && slow_id == 8'h29 |-> slow_data == {4'h0, serial_number_high_word[15:8]})
    else $error("serial byte wrong");
  fast_func_a: assert property (!setup_protocol[5] && (error_flags & 11'h217) != 11'h000 |=> fast_payload == 12'hFFA)
    else $error("function error code missing");
  fast_clean_a: assert property (!setup_protocol[5] && (error_flags & 11'h6FF) == 11'h000 |=> fast_payload == $past(fast_value))
    else $error("clean payload not passed through");
endmodule // sscs_chk

bind sscs_sequencer sscs_chk #(.MFR_CODE(MFR_CODE)) chk (.mclk(mclk), .sys_rst(sys_rst),
  .setup_protocol(setup_protocol), .customer_word_0(customer_word_0),
  .serial_number_high_word(serial_number_high_word), .error_flags(error_flags), .fast_value(fast_value),
  .fast_payload(fast_payload), .slow_valid(slow_valid), .slow_ready(slow_ready), .slow_id(slow_id),
  .slow_data(slow_data), .slow_active(slow_active));

// *** verification/sscs_ecu_model.sv ***
// receiving controller model: takes slow words, may stall
`timescale 1ns/1ps
module sscs_ecu_model (
  // clock
  input wire mclk,
  // slow channel
  input wire slow_valid,
  output reg slow_ready,
  input wire [7:0] slow_id,
  input wire [11:0] slow_data,
  // control
  input wire stall_en
);
  logic [19:0] q [$];
  reg [1:0] cnt_reg = 2'h0;
  initial slow_ready = 1'b0;
  // kept as id/data pairs in arrival order; the bench compares them by position
  always @(posedge mclk) if (slow_valid && slow_ready) q.push_back({slow_id, slow_data});
  always @(negedge mclk) begin
    cnt_reg <= cnt_reg + 2'h1;
    slow_ready <= !stall_en || cnt_reg == 2'h3;
  end
endmodule // sscs_ecu_model

// *** verification/testbench.sv ***
// self-checking bench for the slow channel sequencer
`timescale 1ns/1ps
module testbench;
  localparam [11:0] MFR = 12'h0A5;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg [15:0] sp = 16'h0000;
  reg [15:0] cw [0:9];
  reg [31:0] sn = 32'hA1B2C3D4;
  reg [11:0] tc = 12'h000;
  reg [10:0] ef = 11'h000;
  reg [11:0] fv = 12'h000;
  reg [3:0] fs = 4'h0;
  reg [23:0] fd = 24'h000000;
  reg stall = 1'b0;
  // clamp limits kept as bench registers so the mirror logic sees real inputs
  reg [11:0] cl = 12'h100;
  reg [11:0] ch = 12'hE00;
  wire [3:0] crc;
  wire [11:0] pay;
  wire sv, sr;
  wire [7:0] sid;
  wire [11:0] sd;
  wire [2:0] blk;
  int miscompares = 0;
  int n_checks = 0;
  logic [19:0] qe [$];
  initial forever #25 mclk = ~mclk;
  sscs_sequencer #(.MFR_CODE(MFR)) dut (.mclk(mclk), .sys_rst(sys_rst), .setup_protocol(sp),
    .customer_word_0(cw[0]), .customer_word_1(cw[1]), .customer_word_2(cw[2]), .customer_word_3(cw[3]),
    .customer_word_4(cw[4]), .customer_word_5(cw[5]), .customer_word_6(cw[6]), .customer_word_7(cw[7]),
    .customer_word_8(cw[8]), .customer_word_9(cw[9]), .serial_number_high_word(sn[31:16]),
    .serial_number_low_word(sn[15:0]), .clamp_low(cl), .clamp_high(ch), .temperature_code(tc),
    .error_flags(ef), .fast_value(fv), .frame_status(fs), .frame_data(fd), .frame_crc(crc),
    .fast_payload(pay), .slow_valid(sv), .slow_ready(sr), .slow_id(sid), .slow_data(sd), .slow_block(blk),
    .slow_active());
  sscs_ecu_model rx (.mclk(mclk), .slow_valid(sv), .slow_ready(sr), .slow_id(sid), .slow_data(sd),
    .stall_en(stall));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task restart(input [15:0] s);
    @(negedge mclk);
    sys_rst = 1'b1;
    sp = s;
    repeat (4) @(negedge mclk);
    rx.q.delete();
    sys_rst = 1'b0;
  endtask
  task get_n(input int n);
    int t;
    t = 0;
    while (rx.q.size() < n && t < 2000) begin
      @(negedge mclk);
      t++;
    end
    if (rx.q.size() < n) begin
      miscompares++;
      print_verdict;
    end
  endtask
  function logic [19:0] ent(input int b, input int k);
    logic [47:0] w;
    logic [7:0] base;
    if (b == 0) return k == 1 ? {8'h03, cw[0][11:0]} : k == 2 ? {8'h05, MFR} : k == 3 ? {8'h06, 12'h004} :
      {8'h23, tc < 12'h001 ? 12'h001 : tc > 12'hFF8 ? 12'hFF8 : tc};
    if (b == 1) return {8'h28 + 8'(k), 4'h0, sn[(4 - k) * 8 +: 8]};
    // values packed back to back across three words
    w = {cw[3 * b - 3], cw[3 * b - 4], cw[3 * b - 5]};
    base = b == 2 ? 8'h06 : b == 3 ? 8'h8F : 8'h93;
    return {base + 8'(k), w[(k - 1) * 12 +: 12]};
  endfunction
  task t_seq(input [3:0] en, input bit il, input [11:0] t, input [10:0] e);
    tc = t;
    ef = e;
    stall = ~stall;
    restart({en, 8'h00, il, 3'h0});
    qe.delete();
    for (int p = 0; p < 2; p++)
      for (int b = 0; b < 5; b++)
        if (b == 0 || en[b - 1])
          for (int k = 0; k < 5; k++) begin
            if (k == 0 || (il && k > 1)) qe.push_back({8'h01, 1'b1, e[10:9], 1'b0, e[7:0]});
            if (k > 0) qe.push_back(ent(b, k));
          end
    get_n(qe.size());
    foreach (qe[i]) chk(rx.q[i], qe[i]);
  endtask
  task t_off;
    restart(16'h0010);
    repeat (20) @(negedge mclk);
    chk(rx.q.size(), 0);
    chk(sv, 1'b0);
    sp = 16'h0000;
    get_n(2);
    chk(rx.q[1][19:12], 8'h03);
    chk(blk, 3'h0);
  endtask
  function logic [3:0] step(input [3:0] c);
    logic [3:0] r;
    r = c;
    repeat (4) r = {r[2:0], 1'b0} ^ (r[3] ? 4'hD : 4'h0);
    return r;
  endfunction
  task t_crc;
    logic [3:0] c;
    for (int m = 0; m < 8; m++) begin
      @(negedge mclk);
      sp[11:10] = m[1:0];
      fs = 4'h9 ^ m[3:0];
      fd = 24'(24'h1E5C37 * (m + 1));
      c = sp[10] ? step(4'h5) ^ fs : 4'h5;
      for (int i = 0; i < 6; i++) c = step(c) ^ fd[(5 - i) * 4 +: 4];
      // zero nibble appended only by the recommended variant
      if (!sp[11]) c = step(c);
      @(negedge mclk);
      chk(crc, c);
    end
  endtask
  task t_fast;
    logic [10:0] e [7] = '{11'h000, 11'h21F, 11'h4C8, 11'h020, 11'h020, 11'h217, 11'h100};
    logic [11:0] v [7] = '{12'h555, 12'h555, 12'h555, 12'hF00, 12'h050, 12'h123, 12'h321};
    logic [11:0] x [7] = '{12'h555, 12'hFFA, 12'hFFB, 12'hE00, 12'h100, 12'h123, 12'h321};
    for (int i = 0; i < 7; i++) begin
      @(negedge mclk);
      ef = e[i];
      fv = v[i];
      sp[5] = i == 5;
      @(negedge mclk);
      chk(pay, x[i]);
    end
  endtask
  initial begin
    for (int i = 0; i < 10; i++) cw[i] = 16'h3C5A ^ 16'(i * 16'h1357);
    t_seq(4'h0, 1'b0, 12'h000, 11'h000);
    t_seq(4'hF, 1'b0, 12'hFFF, 11'h7FF);
    t_seq(4'hA, 1'b1, 12'h7A3, 11'h0C5);
    t_off;
    t_crc;
    t_fast;
    print_verdict;
  end
endmodule // testbench
